// ### bench/dof_master.sv
// Purpose: two-wire bus master model reading and writing the status link
// Assumes: sda has a pull-up; scl stands high between frames
// Notes:   30 ns scl period; write data bytes are zero
`timescale 1ns/100ps
module dof_master (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // data moves only while scl is low
  task automatic bit_x(input logic b, output logic r);
    sda_low_o = ~b;
    #7.5 scl_o = 1'b1;
    #7.5 r = sda_i;
    scl_o = 1'b0;
    #15;
  endtask : bit_x

  task automatic xfer(input logic [6:0] a, input logic rd, input int n,
                      output logic [7:0] d [4], output logic ak);
    logic       r;
    logic [7:0] ab;
    ab = {a, rd};
    sda_low_o = 1'b1;
    #7.5 scl_o = 1'b0;
    #7.5;
    for (int i = 7; i >= 0; i--) begin
      bit_x(ab[i], r);
    end
    bit_x(1'b1, r);
    ak = ~r;
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_x(rd, d[k][i]);
      end
      // nack on the last read byte ends the slave's drive
      bit_x(rd ? (k == n - 1) : 1'b1, r);
    end
    sda_low_o = 1'b1;
    #7.5 scl_o = 1'b1;
    #7.5 sda_low_o = 1'b0;
    #15;
  endtask : xfer
endmodule : dof_master

// ### bench/tb.sv
// Purpose: self-checking bench of the status flag block
// Assumes: overcurrent timeout shortened to 20 cycles
// Notes:   row inputs {pbad, tone, hi, lo, ctest, oc}, outputs {st1, st2}
`timescale 1ns/100ps
module tb;
  logic       clk_i, reset_n_i, scl, m_low, sda_oe, sda_o, thermal, supply, oc_en, irq;
  logic [1:0] oc, pbad, hi, lo, tone, on_ctl, ctest, drive;
  logic [7:0] d [4];
  logic       ak;
  int         fails = 0;
  int         total_checks = 0;
  int         cyc = 0;
  wire logic  sda_w = ~(m_low | (sda_oe & ~sda_o));
  logic [27:0] rows [12] = '{28'h400_1000, 28'h800_2000, 28'h100_0004, 28'h200_0008,
    28'h0CC_0003, 28'h00C_0003, 28'h03C_0000, 28'h0CC_0003, 28'h000_0000,
    28'h001_0400, 28'h002_0800, 28'h000_0000};
  // {supply, thermal, oc1}, first read, second read, drive
  logic [20:0] ft [3] = '{{3'b010, 8'h73, 8'h33, 2'b00}, {3'b100, 8'hB3, 8'h33, 2'b00},
    {3'b001, 8'h15, 8'h11, 2'b10}};

  dof_master u_mst (.sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));

  dof_status #(.OCP_CYCLES_P(20)) u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .overcurrent_i(oc), .thermal_trip_i(thermal),
    .supply_low_i(supply), .power_bad_i(pbad), .cable_above_hi_i(hi),
    .cable_below_lo_i(lo), .tone_present_i(tone), .output_on_ctrl_i(on_ctl),
    .cable_test_ctrl_i(ctest), .oc_timer_en_i(oc_en), .output_drive_o(drive),
    .irq_o(irq));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  task automatic rd1(input logic [7:0] s1);
    u_mst.xfer(7'h10, 1'b1, 1, d, ak);
    wt(8);
    chk(d[0], s1);
  endtask : rd1

  task automatic rd4(input logic [7:0] s1, input logic [7:0] s2);
    u_mst.xfer(7'h10, 1'b1, 4, d, ak);
    wt(8);
    chk({d[0], d[1]}, {s1, s2});
    chk({d[2], d[3]}, {s1, s2});
  endtask : rd4

  task automatic wr();
    u_mst.xfer(7'h10, 1'b0, 1, d, ak);
    wt(8);
  endtask : wr

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // hang guard, far above the expected 1800 or so cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    reset_n_i = 1'b0;
    {oc, thermal, supply, pbad, hi, lo, tone, on_ctl, ctest, oc_en} = '0;
    wt(20);
    reset_n_i <= 1'b1;
    wt(10);
    chk({irq, drive}, 3'b000);
    rd4(8'h33, 8'h00);
    on_ctl <= 2'b11;
    wr();
    chk(drive, 2'b11);
    rd4(8'h00, 8'h00);
    for (int i = 0; i < 12; i++) begin
      {pbad, tone, hi, lo, ctest, oc} <= rows[i][27:16];
      wt(8);
      rd4(rows[i][15:8], rows[i][7:0]);
    end
    // address nobody answers to
    u_mst.xfer(7'h11, 1'b1, 0, d, ak);
    wt(1);
    chk(ak, 1'b0);
    oc_en <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      {supply, thermal, oc[0]} <= ft[i][20:18];
      wt(40);
      {supply, thermal, oc[0]} <= 3'b000;
      wt(8);
      chk({irq, drive}, {1'b1, ft[i][1:0]});
      rd1(ft[i][17:10]);
      chk(irq, 1'b0);
      rd1(ft[i][9:2]);
      wr();
      rd1(8'h00);
    end
    on_ctl <= 2'b01;
    wt(8);
    chk({irq, drive}, 3'b001);
    rd1(8'h22);
    // read while still hot, then after it cools
    thermal <= 1'b1;
    wt(8);
    rd1(8'h73);
    chk(irq, 1'b1);
    thermal <= 1'b0;
    wt(8);
    rd1(8'h73);
    rd1(8'h33);
    wr();
    chk(drive, 2'b01);
    // reset in mid-run with the link idle
    reset_n_i <= 1'b0;
    wt(2);
    chk({irq, drive}, 3'b000);
    reset_n_i <= 1'b1;
    wt(10);
    rd1(8'h33);
    end_of_test();
  end
endmodule : tb

// ### core/dof_link.sv
// Purpose: two-wire serial slave facing the master, on the master's clock
// Assumes: start and stop are sda edges while scl is high
// Notes:   write bytes are only acknowledged; the control path lives elsewhere
`timescale 1ns/100ps
module dof_link
  import dof_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
  input  wire logic   scl_i,
  input  wire logic   sda_i,
  input  wire logic   reset_n_i,
  output logic        sda_o,
  output logic        sda_oe_o,
  dof_link_if.link    lnk
);

  logic           start_tog_r;
  logic           stop_tog_r;
  logic           start_ack_r;
  dof_lnk_state_t state_r;
  logic [3:0]     cnt_r;
  logic [7:0]     sh_r;
  logic [7:0]     tx_r;
  logic           sel_r;
  logic           rd9_tog_r;
  logic           wr_seen_r;
  logic           mb_s1_r;
  logic           mb_s2_r;
  logic           mb_ack_r;
  logic [15:0]    shadow_r;
  logic           addr_hit;

  assign addr_hit         = (sh_r[7:1] == DEV_ADDR);
  assign lnk.stop_tog     = stop_tog_r;
  assign lnk.rd9_tog      = rd9_tog_r;
  assign lnk.wr_seen      = wr_seen_r;
  assign lnk.mbox_ack_tog = mb_ack_r;

  // ----------------------------------------------------------------
  // start and stop, clocked by sda itself
  // ----------------------------------------------------------------
  always_ff @(negedge sda_i or negedge reset_n_i) begin
    if (!reset_n_i) start_tog_r <= 1'b0;
    else if (scl_i) start_tog_r <= ~start_tog_r;
  end

  // stop has no scl edge after it, so the core takes it over directly
  always_ff @(posedge sda_i or negedge reset_n_i) begin
    if (!reset_n_i) stop_tog_r <= 1'b0;
    else if (scl_i) stop_tog_r <= ~stop_tog_r;
  end

  // ----------------------------------------------------------------
  // status snapshot mailbox
  // ----------------------------------------------------------------
  always_ff @(posedge scl_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mb_s1_r  <= 1'b0;
      mb_s2_r  <= 1'b0;
      mb_ack_r <= 1'b0;
      shadow_r <= MBOX_RST;
    end else begin
      mb_s1_r <= lnk.mbox_tog;
      mb_s2_r <= mb_s1_r;
      if (mb_s2_r != mb_ack_r) begin
        shadow_r <= lnk.mbox_data;
        mb_ack_r <= mb_s2_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------
  // start settles three quarters of a period before the next rising scl edge
  always_ff @(posedge scl_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      start_ack_r <= 1'b0;
      state_r     <= LNK_IDLE;
      cnt_r       <= 4'h0;
      sh_r        <= 8'h00;
      tx_r        <= 8'h00;
      sel_r       <= SEL_REG1;
      rd9_tog_r   <= 1'b0;
      wr_seen_r   <= 1'b0;
    end else if (start_tog_r != start_ack_r) begin
      start_ack_r <= start_tog_r;
      state_r     <= LNK_ADDR;
      cnt_r       <= BIT_FIRST;
      sh_r        <= {sh_r[6:0], sda_i};
      wr_seen_r   <= 1'b0;
    end else begin
      case (state_r)
        LNK_ADDR: begin
          if (cnt_r != BIT_ACK) begin
            sh_r  <= {sh_r[6:0], sda_i};
            cnt_r <= cnt_r + 4'h1;
          end else begin
            cnt_r <= 4'h0;
            if (addr_hit) begin
              state_r   <= sh_r[0] ? LNK_READ : LNK_WRITE;
              wr_seen_r <= ~sh_r[0];
              sel_r     <= SEL_REG1;
              tx_r      <= shadow_r[7:0];
            end else begin
              state_r <= LNK_IDLE;
            end
          end
        end
        LNK_WRITE: begin
          cnt_r <= (cnt_r != BIT_ACK) ? cnt_r + 4'h1 : 4'h0;
        end
        LNK_READ: begin
          if (cnt_r != BIT_ACK) begin
            tx_r  <= {tx_r[6:0], 1'b0};
            cnt_r <= cnt_r + 4'h1;
          end else begin
            rd9_tog_r <= ~rd9_tog_r;
            cnt_r     <= 4'h0;
            sel_r     <= ~sel_r;
            tx_r      <= sel_r ? shadow_r[7:0] : shadow_r[15:8];
            if (sda_i) state_r <= LNK_IDLE;
          end
        end
        default: state_r <= LNK_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // open-drain drive, changed on the falling edge
  // ----------------------------------------------------------------
  always_ff @(negedge scl_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      case (state_r)
        LNK_ADDR:  sda_oe_o <= (cnt_r == BIT_ACK) && addr_hit;
        LNK_WRITE: sda_oe_o <= (cnt_r == BIT_ACK);
        LNK_READ:  sda_oe_o <= (cnt_r != BIT_ACK) && !tx_r[7];
        default:   sda_oe_o <= 1'b0;
      endcase
    end
  end

endmodule : dof_link

// ### core/dof_status.sv
// Purpose: status flags of a dual supply output, read over a two-wire link
// Assumes: fault, comparator and tone pins are asynchronous to clk_i;
//          control inputs come from logic on clk_i
// Notes:   long overcurrent timeout is a parameter to allow short sims
`timescale 1ns/100ps
module dof_status
  import dof_pkg::*;
#(
  parameter int         OCP_CYCLES_P = OCP_CYCLES,
  parameter logic [6:0] DEV_ADDR     = DEV_ADDR_DEF
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic [1:0] overcurrent_i,
  input  wire logic       thermal_trip_i,
  input  wire logic       supply_low_i,
  input  wire logic [1:0] power_bad_i,
  input  wire logic [1:0] cable_above_hi_i,
  input  wire logic [1:0] cable_below_lo_i,
  input  wire logic [1:0] tone_present_i,
  input  wire logic [1:0] output_on_ctrl_i,
  input  wire logic [1:0] cable_test_ctrl_i,
  input  wire logic       oc_timer_en_i,
  output logic [1:0]      output_drive_o,
  output logic            irq_o
);

  localparam int             OCW     = $clog2(OCP_CYCLES_P + 1);
  localparam logic [OCW-1:0] OC_LAST = OCW'(OCP_CYCLES_P - 1);
  localparam int             NSYNC   = 16;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  dof_link_if lnk ();

  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] raw_in;
  logic             rd9_d_r;
  logic             stop_d_r;
  logic [1:0]       oc_s;
  logic             thermal_s;
  logic             supply_s;
  logic [1:0]       pbad_s;
  logic [1:0]       cab_hi_s;
  logic [1:0]       cab_lo_s;
  logic [1:0]       tone_s;
  logic             rd9_s;
  logic             stop_s;
  logic             wr_seen_s;
  logic             mbox_ack_s;
  logic             rd9_ev;
  logic             wr_end_ev;
  logic [OCW-1:0]   oc_cnt_r [2];
  logic [1:0]       oc_trip;
  logic [1:0]       oc_flag_r;
  logic             thermal_r;
  logic             supply_r;
  logic [1:0]       off_r;
  logic [1:0]       cab_r;
  logic             irq_r;
  logic             mbox_tog_r;
  logic [15:0]      mbox_data_r;
  logic [7:0]       st1;
  logic [7:0]       st2;

  // ----------------------------------------------------------------
  // serial link on the master's clock
  // ----------------------------------------------------------------
  dof_link #(
    .DEV_ADDR (DEV_ADDR)
  ) u_link (
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .reset_n_i (reset_n_i),
    .sda_o     (sda_o),
    .sda_oe_o  (sda_oe_o),
    .lnk       (lnk.link)
  );

  assign lnk.mbox_tog  = mbox_tog_r;
  assign lnk.mbox_data = mbox_data_r;

  // ----------------------------------------------------------------
  // input synchronisers: pins and link toggles alike
  // ----------------------------------------------------------------
  assign raw_in = {lnk.rd9_tog, lnk.stop_tog, lnk.wr_seen, lnk.mbox_ack_tog,
                   tone_present_i, cable_below_lo_i, cable_above_hi_i,
                   power_bad_i, supply_low_i, thermal_trip_i, overcurrent_i};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  assign {rd9_s, stop_s, wr_seen_s, mbox_ack_s, tone_s, cab_lo_s, cab_hi_s,
          pbad_s, supply_s, thermal_s, oc_s} = sync2_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd9_d_r  <= 1'b0;
      stop_d_r <= 1'b0;
    end else begin
      rd9_d_r  <= rd9_s;
      stop_d_r <= stop_s;
    end
  end

  assign rd9_ev    = rd9_s ^ rd9_d_r;
  assign wr_end_ev = (stop_s ^ stop_d_r) && wr_seen_s;

  // ----------------------------------------------------------------
  // overcurrent timers
  // ----------------------------------------------------------------
  // counts only while the condition holds; any gap restarts the wait
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oc_cnt_r[0] <= '0;
      oc_cnt_r[1] <= '0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (!oc_s[ch] || !oc_timer_en_i) oc_cnt_r[ch] <= '0;
        else if (oc_cnt_r[ch] != OC_LAST) oc_cnt_r[ch] <= oc_cnt_r[ch] + OCW'(1);
      end
    end
  end

  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      oc_trip[ch] = oc_timer_en_i && oc_s[ch] && (oc_cnt_r[ch] == OC_LAST);
    end
  end

  // ----------------------------------------------------------------
  // latched fault flags
  // ----------------------------------------------------------------
  // a new trip in the read cycle wins over the clear
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oc_flag_r <= 2'b00;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (!oc_timer_en_i) oc_flag_r[ch] <= oc_s[ch];
        else if (oc_trip[ch]) oc_flag_r[ch] <= 1'b1;
        else if (rd9_ev) oc_flag_r[ch] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      thermal_r <= 1'b0;
      supply_r  <= 1'b0;
    end else begin
      if (thermal_s) thermal_r <= 1'b1;
      else if (rd9_ev) thermal_r <= 1'b0;
      if (supply_s) supply_r <= 1'b1;
      else if (rd9_ev) supply_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output-off flags and output drive
  // ----------------------------------------------------------------
  // supply low keeps this set until a write ends with the enable on
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      off_r <= 2'b11;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (oc_trip[ch] || thermal_s || supply_s || !output_on_ctrl_i[ch]) begin
          off_r[ch] <= 1'b1;
        end else if (wr_end_ev) begin
          off_r[ch] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) output_drive_o <= 2'b00;
    else output_drive_o <= ~off_r;
  end

  // ----------------------------------------------------------------
  // cable test result
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cab_r <= 2'b00;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (!cable_test_ctrl_i[ch]) cab_r[ch] <= 1'b0;
        else if (cab_hi_s[ch]) cab_r[ch] <= 1'b1;
        else if (cab_lo_s[ch]) cab_r[ch] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  // output-off is left out: switching off may be intended
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) irq_r <= 1'b0;
    else irq_r <= |{oc_flag_r, thermal_r, supply_r};
  end

  assign irq_o = irq_r;

  // ----------------------------------------------------------------
  // status bytes
  // ----------------------------------------------------------------
  always_comb begin
    st1               = 8'h00;
    st1[ST1_OFF_CH1]  = off_r[0];
    st1[ST1_OFF_CH2]  = off_r[1];
    st1[ST1_OC_CH1]   = oc_flag_r[0];
    st1[ST1_OC_CH2]   = oc_flag_r[1];
    st1[ST1_PBAD_CH1] = pbad_s[0] | off_r[0];
    st1[ST1_PBAD_CH2] = pbad_s[1] | off_r[1];
    st1[ST1_THERMAL]  = thermal_r;
    st1[ST1_SUPPLY]   = supply_r;
    st2               = 8'h00;
    st2[ST2_CAB_CH1]  = cab_r[0];
    st2[ST2_CAB_CH2]  = cab_r[1];
    st2[ST2_TONE_CH1] = tone_s[0];
    st2[ST2_TONE_CH2] = tone_s[1];
  end

  // ----------------------------------------------------------------
  // snapshot handshake toward the link
  // ----------------------------------------------------------------
  // refreshed only when the link has taken the last word, so the
  // word is stable while it crosses; a byte may be a few scl old
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mbox_tog_r  <= 1'b0;
      mbox_data_r <= MBOX_RST;
    end else if (mbox_tog_r == mbox_ack_s) begin
      mbox_data_r <= {st2, st1};
      mbox_tog_r  <= ~mbox_tog_r;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_trip_sets_flags: assert property (
    oc_trip[0] |=> oc_flag_r[0] && off_r[0] ##1 !output_drive_o[0])
    else $error("overcurrent trip did not flag and disable channel 1");

  chk_read_clears_oc: assert property (
    rd9_ev && oc_timer_en_i && !oc_trip[0] ##1 oc_timer_en_i |-> !oc_flag_r[0])
    else $error("read did not clear overcurrent flag");

  chk_oc_follows_live: assert property (
    !oc_timer_en_i |=> oc_flag_r[0] == $past(oc_s[0]))
    else $error("overcurrent flag not following condition");

  chk_thermal_stays_set: assert property (
    rd9_ev && thermal_s |=> thermal_r && off_r == 2'b11)
    else $error("thermal flag or disables dropped while hot");

  chk_supply_clear_read: assert property (
    supply_r && rd9_ev && !supply_s |=> !supply_r)
    else $error("supply flag not cleared by read after recovery");

  chk_supply_keeps_off: assert property (
    off_r[1] && !wr_end_ev |=> off_r[1])
    else $error("output-off cleared without a write");

  chk_write_enables: assert property (
    wr_end_ev && output_on_ctrl_i[0] && !oc_trip[0] && !thermal_s && !supply_s
    |=> !off_r[0] ##1 output_drive_o[0])
    else $error("write end did not re-enable channel 1");

  chk_off_no_irq: assert property (
    $rose(off_r[0]) && !(|{oc_flag_r, thermal_r, supply_r}) |=> !irq_o)
    else $error("interrupt raised by output-off alone");

  chk_pbad_when_off: assert property (
    off_r[1] |-> st1[ST1_PBAD_CH2])
    else $error("power-bad low while output off");

  chk_cable_test_stop: assert property (
    !cable_test_ctrl_i[0] |=> !cab_r[0])
    else $error("cable-open held after test stopped");

  chk_irq_release: assert property (
    $fell(|{oc_flag_r, thermal_r, supply_r}) |=> !irq_o)
    else $error("interrupt held after latched flags cleared");

  chk_irq_on_fault: assert property (
    $rose(thermal_r) |=> irq_o)
    else $error("interrupt not raised by thermal flag");

  chk_cable_open_set: assert property (
    cable_test_ctrl_i[0] && cab_hi_s[0] |=> cab_r[0])
    else $error("cable-open not set above high threshold");

  cov_oc_trip:      cover property (oc_trip[0] ##1 oc_flag_r[0]);
  cov_thermal_read: cover property (thermal_r && rd9_ev && !thermal_s ##1 !thermal_r);
  cov_write_end:    cover property (wr_end_ev ##1 !off_r[0]);
  cov_cable_open:   cover property ($rose(cab_r[1]));

endmodule : dof_status

// ### include/dof_link_if.sv
// Purpose: carrier between the serial link logic and the status core
// Assumes: toggles and levels cross with two flops on the receiving side
// Notes:   mbox_data is held stable while mbox_tog differs from mbox_ack_tog
`timescale 1ns/100ps
interface dof_link_if;
  logic        rd9_tog;
  logic        stop_tog;
  logic        wr_seen;
  logic        mbox_tog;
  logic [15:0] mbox_data;
  logic        mbox_ack_tog;

  modport link (
    output rd9_tog,
    output stop_tog,
    output wr_seen,
    output mbox_ack_tog,
    input  mbox_tog,
    input  mbox_data
  );

  modport core (
    input  rd9_tog,
    input  stop_tog,
    input  wr_seen,
    input  mbox_ack_tog,
    output mbox_tog,
    output mbox_data
  );
endinterface : dof_link_if

// ### include/dof_pkg.sv
// Purpose: shared constants and types of the dual-output status flag block
// Assumes: core clock of 40 MHz; serial link clocked by the master's clock
// Notes:   status bytes are 8 bits; unused high bits of byte 2 read zero
package dof_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 40_000_000;
  localparam int OCP_TIME_MS = 48;
  localparam int OCP_CYCLES  = OCP_TIME_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // link
  // ----------------------------------------------------------------
  // device address: value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEF = 7'h10;
  localparam logic [3:0] BIT_ACK      = 4'h8;
  localparam logic [3:0] BIT_FIRST    = 4'h1;
  localparam logic       SEL_REG1     = 1'b0;

  typedef enum logic [1:0] {
    LNK_IDLE  = 2'b00,
    LNK_ADDR  = 2'b01,
    LNK_WRITE = 2'b10,
    LNK_READ  = 2'b11
  } dof_lnk_state_t;

  // ----------------------------------------------------------------
  // fault_status_primary field positions
  // ----------------------------------------------------------------
  localparam int ST1_OFF_CH1  = 0;
  localparam int ST1_OFF_CH2  = 1;
  localparam int ST1_OC_CH1   = 2;
  localparam int ST1_OC_CH2   = 3;
  localparam int ST1_PBAD_CH1 = 4;
  localparam int ST1_PBAD_CH2 = 5;
  localparam int ST1_THERMAL  = 6;
  localparam int ST1_SUPPLY   = 7;

  // ----------------------------------------------------------------
  // cable_tone_status field positions
  // ----------------------------------------------------------------
  localparam int ST2_CAB_CH1  = 0;
  localparam int ST2_CAB_CH2  = 1;
  localparam int ST2_TONE_CH1 = 2;
  localparam int ST2_TONE_CH2 = 3;

  // outputs off and power bad at power-on
  localparam logic [7:0]  ST1_RST  = 8'h33;
  localparam logic [7:0]  ST2_RST  = 8'h00;
  localparam logic [15:0] MBOX_RST = {ST2_RST, ST1_RST};

endpackage : dof_pkg
